// ### dv/pmt_timer_props.sv
// Concurrent checks on the ports of the period match timer.
`timescale 1ns/1ps
module pmt_timer_props
    import pmt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pmt_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [pmt_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic [pmt_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [pmt_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic matchPulse,
    input wire logic irq
);
    // =========================================================
    // Bus and timer properties
    // =========================================================
    // One clock domain, so reset disables every check in one place.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_ack_next;
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");

    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && wb_cyc_i;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

    property p_byte_wide;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("read data above bit 7");

    property p_ctrl_top;
        wb_ack_o && !wb_we_i && wb_adr_i == OFF_CONTROL |-> !wb_dat_o[7];
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control bit 7 read as one");

    // Matches can only come on instruction ticks, four clocks apart at the least.
    property p_pulse_gap;
        matchPulse |=> !matchPulse [*3];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap) else $error("match pulses too close");

    property p_irq_rise;
        $rose(irq) |-> matchPulse || $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");

    property p_irq_fall;
        $fell(irq) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without software write");
endmodule : pmt_timer_props

bind pmt_timer pmt_timer_props pmt_timer_props_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .matchPulse(matchPulse), .irq(irq));

// ### dv/pmt_timer_tb_top.sv
// Self-checking testbench of the period match timer.
`timescale 1ns/1ps
module pmt_timer_tb_top;
    import pmt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDat = 32'h0;
    logic [3:0] wbSel = 4'h1;
    logic [31:0] datOut;
    logic ackOut;
    logic matchPulse;
    logic irq;
    int numErrors = 0;
    int testsRun = 0;
    int cycleNum = 0;
    logic [31:0] seed = 32'hc3b6;

    // =========================================================
    // Clock, cycle count and design
    // =========================================================
    // The cycle count times match pulses, since the instruction phase is never cleared.
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cycleNum <= cycleNum + 1;

    pmt_timer pmt_timer_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_dat_o(datOut), .wb_ack_o(ackOut),
        .matchPulse(matchPulse), .irq(irq));

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [31:0] pmt_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : pmt_lfsr

    // Clocks between match pulses: four per tick, times prescale, period plus one, postscale.
    function automatic logic [31:0] exp_gap(input int pre, input int post, input int per);
        int div;
        div = (pre == 0) ? 1 : (pre == 1) ? 4 : 16;
        return 4 * div * (per + 1) * (post + 1);
    endfunction : exp_gap

    task completeRun;
        $display("checks %0d errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : completeRun

    task check(input logic [31:0] seen, input logic [31:0] expd);
        testsRun++;
        if (seen !== expd)
        begin
            numErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    // Classic cycle: hold everything until ack is seen, take data at that edge, then release.
    task wbXfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= {24'h0, dat};
        n = 0;
        @(negedge sys_clk);
        while (ackOut !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                numErrors++;
                completeRun;
            end
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        rd = datOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wbXfer

    task wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] x;
        wbXfer(1'b1, adr, dat, x);
    endtask : wr

    task rdChk(input logic [7:0] adr, input logic [31:0] expd);
        logic [31:0] x;
        wbXfer(1'b0, adr, 8'h00, x);
        check(x, expd);
    endtask : rdChk

    task waitPulse(output int t);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (matchPulse !== 1'b1)
        begin
            n++;
            if (n > 5000)
            begin
                numErrors++;
                completeRun;
            end
            @(negedge sys_clk);
        end
        t = cycleNum;
    endtask : waitPulse

    // =========================================================
    // Main sequence
    // =========================================================
    initial
    begin
        logic [31:0] x;
        int t1;
        int t2;
        int per;
        int post;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(OFF_COUNT, 32'h00);
        rdChk(OFF_PERIOD, 32'hff);
        rdChk(OFF_CONTROL, 32'h00);
        rdChk(8'h20, 32'h00);
        seed = pmt_lfsr(seed);
        wr(OFF_PERIOD, seed[7:0]);
        rdChk(OFF_PERIOD, {24'h0, seed[7:0]});
        // A write without lane zero is acknowledged but must leave the register alone.
        wbSel <= 4'he;
        wr(OFF_PERIOD, ~seed[7:0]);
        wbSel <= 4'h1;
        rdChk(OFF_PERIOD, {24'h0, seed[7:0]});
        wr(OFF_CONTROL, 8'hff);
        rdChk(OFF_CONTROL, 32'h7f);
        // Every prescale code, random period and postscale, the longest postscale as a corner.
        for (int pre = 0; pre < 4; pre++)
        begin
            seed = pmt_lfsr(seed);
            per = seed[1:0];
            post = (pre == 0) ? 15 : seed[3:2];
            wr(OFF_PERIOD, per[7:0]);
            wr(OFF_COUNT, 8'h00);
            wr(OFF_CONTROL, {1'b0, post[3:0], 1'b1, pre[1:0]});
            waitPulse(t1);
            waitPulse(t2);
            check(t2 - t1, exp_gap(pre, post, per));
        end
        // Stopped timer holds its count and both scalers read zero; a count write still lands.
        wr(OFF_CONTROL, 8'h78);
        rdChk(OFF_SCALER_STATE, 32'h00);
        wbXfer(1'b0, OFF_COUNT, 8'h00, x);
        repeat (100) @(posedge sys_clk);
        rdChk(OFF_COUNT, x);
        wr(OFF_COUNT, 8'h5a);
        rdChk(OFF_COUNT, 32'h5a);
        // A control write that starts the timer keeps the count; one 1:16 step takes 64 clocks.
        wr(OFF_CONTROL, 8'h07);
        rdChk(OFF_COUNT, 32'h5a);
        // Flag, masking by each enable, and clearing.
        wr(OFF_INT_CLEAR, 8'h01);
        rdChk(OFF_INT_STATUS, 32'h00);
        wr(OFF_INT_ENABLE, 8'h01);
        wr(OFF_INT_GATE, 8'h01);
        wr(OFF_PERIOD, 8'h00);
        wr(OFF_CONTROL, 8'h04);
        waitPulse(t1);
        wr(OFF_CONTROL, 8'h00);
        rdChk(OFF_INT_STATUS, 32'h01);
        @(negedge sys_clk);
        check(irq, 1'b0);
        wr(OFF_INT_GATE, 8'h03);
        repeat (3) @(negedge sys_clk);
        check(irq, 1'b1);
        wr(OFF_INT_GATE, 8'h02);
        repeat (3) @(negedge sys_clk);
        check(irq, 1'b0);
        wr(OFF_INT_GATE, 8'h03);
        wr(OFF_INT_ENABLE, 8'h00);
        repeat (3) @(negedge sys_clk);
        check(irq, 1'b0);
        wr(OFF_INT_ENABLE, 8'h01);
        wr(OFF_INT_CLEAR, 8'h01);
        repeat (3) @(negedge sys_clk);
        check(irq, 1'b0);
        rdChk(OFF_INT_STATUS, 32'h00);
        completeRun;
    end
endmodule : pmt_timer_tb_top

// ### src/pmt_pkg.sv
// Package of constants shared by the period match timer files.
package pmt_pkg;

    // =========================================================
    // Bus geometry
    // =========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int REG_W = 8;

    // =========================================================
    // Register byte offsets
    // =========================================================
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_INT_CLEAR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_INT_GATE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SCALER_STATE = 8'h1c;

    // =========================================================
    // Control register fields
    // =========================================================
    localparam int CTRL_PRE_LSB = 0;
    localparam int CTRL_PRE_W = 2;
    localparam int CTRL_ON_BIT = 2;
    localparam int CTRL_POST_LSB = 3;
    localparam int CTRL_POST_W = 4;
    localparam logic [REG_W-1:0] CTRL_WRITE_MASK = 8'h7f;

    // =========================================================
    // Interrupt and scaler state register fields
    // =========================================================
    localparam int INT_MATCH_BIT = 0;
    localparam int GATE_PERIPH_BIT = 0;
    localparam int GATE_GLOBAL_BIT = 1;
    localparam int SCALER_POST_LSB = 4;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [REG_W-1:0] RST_COUNT = 8'h00;
    localparam logic [REG_W-1:0] RST_PERIOD = 8'hff;
    localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;

    // =========================================================
    // Clock division counts
    // =========================================================
    localparam int INSTR_W = 2;
    localparam logic [INSTR_W-1:0] INSTR_LAST = 2'h3;
    localparam int PRE_CNT_W = 4;
    localparam logic [PRE_CNT_W-1:0] PRE_LAST_DIV1 = 4'h0;
    localparam logic [PRE_CNT_W-1:0] PRE_LAST_DIV4 = 4'h3;
    localparam logic [PRE_CNT_W-1:0] PRE_LAST_DIV16 = 4'hf;

    // Bus slave states.
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } pmt_bus_state_type;

endpackage : pmt_pkg

// ### src/pmt_postscaler.sv
// Postscaler that fires after 1 to 16 period matches.
`timescale 1ns/1ps
module pmt_postscaler
    import pmt_pkg::*;
#(
    parameter int CNT_W = pmt_pkg::CTRL_POST_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic match,
    input wire logic [CNT_W-1:0] postscale_select,
    output logic fire,
    output logic [CNT_W-1:0] postCount
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic atLast;

    // A field value N fires on the (N+1)th match.
    assign atLast = (count_reg >= postscale_select);
    assign fire = match && atLast;
    assign count_next = clear ? '0 : (match ? (atLast ? '0 : count_reg + 1'b1) : count_reg);
    assign postCount = count_reg;

    // Counter of matches since the last output.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

endmodule : pmt_postscaler

// ### src/pmt_prescaler.sv
// Prescaler that divides instruction ticks by 1, 4 or 16.
`timescale 1ns/1ps
module pmt_prescaler
    import pmt_pkg::*;
#(
    parameter int CNT_W = pmt_pkg::PRE_CNT_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [pmt_pkg::CTRL_PRE_W-1:0] prescale_select,
    output logic incPulse,
    output logic [CNT_W-1:0] preCount
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] lastCount;
    logic atLast;

    // Terminal count of the selected divide; any value with the top bit set means 16.
    function automatic logic [CNT_W-1:0] last_of(input logic [1:0] sel);
        if (sel[1])
            return CNT_W'(PRE_LAST_DIV16);
        else if (sel[0])
            return CNT_W'(PRE_LAST_DIV4);
        else
            return CNT_W'(PRE_LAST_DIV1);
    endfunction : last_of

    // Divide selection and next count.
    assign lastCount = last_of(prescale_select);
    assign atLast = (count_reg >= lastCount);
    assign incPulse = tick && atLast;
    assign count_next = clear ? '0 : (tick ? (atLast ? '0 : count_reg + 1'b1) : count_reg);
    assign preCount = count_reg;

    // The >= compare recovers cleanly if the divide is lowered mid-count.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

endmodule : pmt_prescaler

// ### src/pmt_timer.sv
// Top of the period match timer with its Wishbone register slave.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module pmt_timer
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pmt_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [pmt_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic [pmt_pkg::SEL_W-1:0] wb_sel_i,
    output logic [pmt_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic matchPulse,
    output logic irq
);
    import pmt_pkg::*;

    // =========================================================
    // Declarations
    // =========================================================

    // Bus slave state and captured read data.
    pmt_bus_state_type busState_reg;
    pmt_bus_state_type busState_next;
    logic [DATA_W-1:0] readData_reg;
    logic [DATA_W-1:0] readData_next;

    // Software visible registers and the registered outputs.
    logic [REG_W-1:0] timer_count_reg;
    logic [REG_W-1:0] timer_count_next;
    logic [REG_W-1:0] period_value_reg;
    logic [REG_W-1:0] period_value_next;
    logic [REG_W-1:0] timer_control_reg;
    logic [REG_W-1:0] timer_control_next;
    logic match_int_flag_reg;
    logic match_int_flag_next;
    logic match_int_enable_reg;
    logic match_int_enable_next;
    logic peripheral_int_enable_reg;
    logic peripheral_int_enable_next;
    logic global_int_enable_reg;
    logic global_int_enable_next;
    logic matchPulse_reg;
    logic irq_reg;
    logic irq_next;

    // Instruction clock phase.
    logic [INSTR_W-1:0] instrPhase_reg;
    logic [INSTR_W-1:0] instrPhase_next;
    logic instrTick;

    // Bus decode.
    logic busRequest;
    logic busAccept;
    logic writeCommit;
    logic laneZero;
    logic wrCount;
    logic wrPeriod;
    logic wrControl;
    logic wrIntClear;
    logic wrIntEnable;
    logic wrIntGate;
    logic [REG_W-1:0] writeByte;
    logic [DATA_W-1:0] readMux;

    // Timer datapath.
    logic timer_run_bit;
    logic [CTRL_PRE_W-1:0] prescale_select;
    logic [CTRL_POST_W-1:0] postscale_select;
    logic scalerClear;
    logic incPulse;
    logic countMatch;
    logic periodMatch;
    logic postFire;
    logic [PRE_CNT_W-1:0] preCount;
    logic [CTRL_POST_W-1:0] postCount;

    // =========================================================
    // Wishbone slave
    // =========================================================

    // A request is taken in IDLE and answered one cycle later. The ACK state always
    // returns to IDLE, so a request still held at the ack edge is not taken twice.
    assign busRequest = wb_cyc_i && wb_stb_i;
    assign busAccept = (busState_reg == BUS_IDLE) && busRequest;
    assign writeCommit = (busState_reg == BUS_ACK) && busRequest && wb_we_i;

    // Registers are one byte wide, so only lane zero carries a write.
    assign laneZero = wb_sel_i[0];
    assign writeByte = wb_dat_i[REG_W-1:0];

    // Write strobes land on the edge where the master samples ack.
    assign wrCount = writeCommit && laneZero && (wb_adr_i == OFF_COUNT);
    assign wrPeriod = writeCommit && laneZero && (wb_adr_i == OFF_PERIOD);
    assign wrControl = writeCommit && laneZero && (wb_adr_i == OFF_CONTROL);
    assign wrIntClear = writeCommit && laneZero && (wb_adr_i == OFF_INT_CLEAR);
    assign wrIntEnable = writeCommit && laneZero && (wb_adr_i == OFF_INT_ENABLE);
    assign wrIntGate = writeCommit && laneZero && (wb_adr_i == OFF_INT_GATE);

    // Read selection; unmapped and write-only offsets read as zero.
    always_comb
    begin
        readMux = '0;
        case (wb_adr_i)
            OFF_COUNT: readMux[REG_W-1:0] = timer_count_reg;
            OFF_PERIOD: readMux[REG_W-1:0] = period_value_reg;
            OFF_CONTROL: readMux[REG_W-1:0] = timer_control_reg & CTRL_WRITE_MASK;
            OFF_INT_STATUS: readMux[INT_MATCH_BIT] = match_int_flag_reg;
            OFF_INT_ENABLE: readMux[INT_MATCH_BIT] = match_int_enable_reg;
            OFF_INT_GATE:
            begin
                readMux[GATE_PERIPH_BIT] = peripheral_int_enable_reg;
                readMux[GATE_GLOBAL_BIT] = global_int_enable_reg;
            end
            OFF_SCALER_STATE:
            begin
                readMux[PRE_CNT_W-1:0] = preCount;
                readMux[SCALER_POST_LSB +: CTRL_POST_W] = postCount;
            end
            default: readMux = '0;
        endcase
    end

    // Next bus state.
    always_comb
    begin
        busState_next = busState_reg;
        case (busState_reg)
            BUS_IDLE:
            begin
                if (busRequest)
                    busState_next = BUS_ACK;
            end
            BUS_ACK: busState_next = BUS_IDLE;
            default: busState_next = BUS_IDLE;
        endcase
    end

    // Read data is captured when the request is taken and held through ack.
    assign readData_next = busAccept ? readMux : readData_reg;
    assign wb_ack_o = (busState_reg == BUS_ACK);
    assign wb_dat_o = readData_reg;

    // Bus slave flip-flops.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            busState_reg <= BUS_IDLE;
            readData_reg <= '0;
        end
        else
        begin
            busState_reg <= busState_next;
            readData_reg <= readData_next;
        end
    end

    // =========================================================
    // Instruction clock
    // =========================================================

    // The instruction tick is one system clock in four and runs free, so the
    // timer phase never depends on when software started it.
    assign instrPhase_next = instrPhase_reg + 1'b1;
    assign instrTick = (instrPhase_reg == INSTR_LAST);

    // Instruction phase counter.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            instrPhase_reg <= '0;
        else
            instrPhase_reg <= instrPhase_next;
    end

    // =========================================================
    // Control fields and scaler chain
    // =========================================================

    // Field extraction from the control register.
    assign timer_run_bit = timer_control_reg[CTRL_ON_BIT];
    assign prescale_select = timer_control_reg[CTRL_PRE_LSB +: CTRL_PRE_W];
    assign postscale_select = timer_control_reg[CTRL_POST_LSB +: CTRL_POST_W];

    // Both scalers restart whenever software touches the count or the control.
    assign scalerClear = wrCount || wrControl;

    // The prescaler only sees ticks while the timer runs.
    pmt_prescaler #(
        .CNT_W(PRE_CNT_W)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(scalerClear),
        .tick(instrTick && timer_run_bit),
        .prescale_select(prescale_select),
        .incPulse(incPulse),
        .preCount(preCount)
    );

    // The comparator is live at all times; a match only acts on an increment.
    assign countMatch = (timer_count_reg == period_value_reg);
    assign periodMatch = incPulse && countMatch;

    // Postscaler driven by period matches.
    pmt_postscaler #(
        .CNT_W(CTRL_POST_W)
    ) u_postscaler (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(scalerClear),
        .match(periodMatch),
        .postscale_select(postscale_select),
        .fire(postFire),
        .postCount(postCount)
    );

    // =========================================================
    // Timer registers
    // =========================================================

    // A software write to the count wins over an increment in the same cycle.
    always_comb
    begin
        timer_count_next = timer_count_reg;
        if (wrCount)
            timer_count_next = writeByte;
        else if (incPulse && countMatch)
            timer_count_next = '0;
        else if (incPulse)
            timer_count_next = timer_count_reg + 1'b1;
    end

    // Period and control; control writes do not disturb the count.
    assign period_value_next = wrPeriod ? writeByte : period_value_reg;
    assign timer_control_next = wrControl ? (writeByte & CTRL_WRITE_MASK) : timer_control_reg;

    // Timer register flip-flops.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_count_reg <= RST_COUNT;
            period_value_reg <= RST_PERIOD;
            timer_control_reg <= RST_CONTROL;
        end
        else
        begin
            timer_count_reg <= timer_count_next;
            period_value_reg <= period_value_next;
            timer_control_reg <= timer_control_next;
        end
    end

    // =========================================================
    // Interrupts
    // =========================================================

    // The flag is sticky; a postscaler output in the cycle of a clear still sets it.
    always_comb
    begin
        match_int_flag_next = match_int_flag_reg;
        if (wrIntClear && writeByte[INT_MATCH_BIT])
            match_int_flag_next = 1'b0;
        if (postFire)
            match_int_flag_next = 1'b1;
    end

    // Enable bits.
    assign match_int_enable_next = wrIntEnable ? writeByte[INT_MATCH_BIT] : match_int_enable_reg;
    assign peripheral_int_enable_next = wrIntGate ? writeByte[GATE_PERIPH_BIT] : peripheral_int_enable_reg;
    assign global_int_enable_next = wrIntGate ? writeByte[GATE_GLOBAL_BIT] : global_int_enable_reg;

    // The request needs the flag and every enable level; the flag still sets with them off.
    assign irq_next = match_int_flag_next && match_int_enable_next
        && peripheral_int_enable_next && global_int_enable_next;

    // Interrupt flip-flops; irq and matchPulse are registered outputs.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            match_int_flag_reg <= 1'b0;
            match_int_enable_reg <= 1'b0;
            peripheral_int_enable_reg <= 1'b0;
            global_int_enable_reg <= 1'b0;
            irq_reg <= 1'b0;
            matchPulse_reg <= 1'b0;
        end
        else
        begin
            match_int_flag_reg <= match_int_flag_next;
            match_int_enable_reg <= match_int_enable_next;
            peripheral_int_enable_reg <= peripheral_int_enable_next;
            global_int_enable_reg <= global_int_enable_next;
            irq_reg <= irq_next;
            matchPulse_reg <= postFire;
        end
    end

    assign irq = irq_reg;
    assign matchPulse = matchPulse_reg;

endmodule : pmt_timer
